// File: verilog/ecp_unit.sv
// one enhanced compare/pwm unit with its timers and avalon-mm registers
// assumes one mclk domain; unit_four_level comes from logic on mclk
`timescale 1ns/1ps
`default_nettype none
module ecp_unit #(
    parameter int UNIT_ID = 1             // 1, 2 or 3
) (
    input  wire logic        mclk,            // 200 mhz clock
    input  wire logic        sys_rst,         // async reset, high
    input  wire logic [7:0]  avs_address,     // byte address
    input  wire logic        avs_read,        // read request
    input  wire logic        avs_write,       // write request
    input  wire logic [31:0] avs_writedata,   // write data
    output logic      [31:0] avs_readdata,    // read data
    output logic             avs_waitrequest, // stall
    input  wire logic        unit_four_level, // compare unit four pin
    output logic             pwm_out_a,       // output a
    output logic             pwm_out_b,       // output b
    output logic             pwm_out_c,       // output c
    output logic             pwm_out_d,       // output d
    output logic             shared_pin_out,  // unit four / d pin
    output logic             sp_trigger,      // special event pulse
    output logic             adc_start        // conversion start pulse
);
    typedef struct packed {
        logic                   ack;
        logic [31:0]            rdata;
        logic [7:0]             ucon;
        logic [7:0]             dlow;
        logic [7:0]             shadow;
        logic [1:0]             latch;
        logic [1:0]             cfg;
        logic [1:0]             pol;
        logic [15:0]            cmp;
        logic [7:0]             per2;
        logic [7:0]             per4;
        logic [8:0]             tctl;
        logic [1:0]             t3c;
        logic [15:0]            tm1;
        logic [15:0]            tm3;
        logic [2:0]             flg;
        logic [6:0]             db;
        logic [6:0]             dba;
        logic [1:0]             q;
        ecp_pkg::ecp_state_t    st;
        logic                   pwm;
        logic                   trig;
        logic                   adc;
        logic [3:0]             outs;
        logic                   shared;
    } ecp_unit_st_t;

    ecp_unit_st_t s;
    ecp_unit_st_t d;
    logic         req;
    logic         wr_acc;
    logic         inst_en;
    logic         pwm_mode;
    logic         duty_match;
    logic [15:0]  csel_cnt;
    logic [31:0]  rd_val;
    logic [7:0]   t2_cnt;
    logic [7:0]   t4_cnt;
    logic [1:0]   t2_sub;
    logic [1:0]   t4_sub;
    logic         t2_hit;
    logic         t4_hit;
    logic [7:0]   cnt_sel;
    logic [1:0]   sub_sel;
    logic         hit_sel;

    // bus handshake: one wait cycle per request
    assign req             = avs_read | avs_write;
    assign wr_acc          = avs_write & s.ack;
    assign avs_waitrequest = req & ~s.ack;
    assign avs_readdata    = s.rdata;

    // quarter-cycle divider gives the instruction enable
    assign inst_en  = (s.q == ecp_pkg::Q_LAST);
    assign pwm_mode = (s.ucon[3:2] == ecp_pkg::MODE_PWM);

    // timer two and timer four period timers
    ecp_period_timer u_period_timer_count (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .inst_en (inst_en),
        .run     (s.tctl[ecp_pkg::T2ON]),
        .presc   (s.tctl[ecp_pkg::T2PS +: 2]),
        .period  (s.per2),
        .q_phase (s.q),
        .count   (t2_cnt),
        .sub     (t2_sub),
        .hit     (t2_hit)
    );
    ecp_period_timer u_alt_period_timer_count (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .inst_en (inst_en),
        .run     (s.tctl[ecp_pkg::T4ON]),
        .presc   (s.tctl[ecp_pkg::T4PS +: 2]),
        .period  (s.per4),
        .q_phase (s.q),
        .count   (t4_cnt),
        .sub     (t4_sub),
        .hit     (t4_hit)
    );

    // time base select and compare timer select
    assign cnt_sel  = s.t3c[ecp_pkg::PSEL] ? t4_cnt : t2_cnt;
    assign sub_sel  = s.t3c[ecp_pkg::PSEL] ? t4_sub : t2_sub;
    assign hit_sel  = s.t3c[ecp_pkg::PSEL] ? t4_hit : t2_hit;
    assign csel_cnt = s.t3c[ecp_pkg::CSEL] ? s.tm3 : s.tm1;
    assign duty_match = ({s.shadow, s.latch} == {cnt_sel, sub_sel});

    // read data mux
    always_comb begin
        case (avs_address)
            ecp_pkg::OFF_UCON: rd_val = {24'h0, s.ucon};
            ecp_pkg::OFF_DLOW: rd_val = {24'h0, s.dlow};
            ecp_pkg::OFF_DSHD: rd_val = {24'h0, s.shadow};
            ecp_pkg::OFF_CMP:  rd_val = {16'h0, s.cmp};
            ecp_pkg::OFF_PER2: rd_val = {24'h0, s.per2};
            ecp_pkg::OFF_PER4: rd_val = {24'h0, s.per4};
            ecp_pkg::OFF_TCTL: rd_val = {23'h0, s.tctl};
            ecp_pkg::OFF_T3C:  rd_val = {30'h0, s.t3c};
            ecp_pkg::OFF_TM1:  rd_val = {16'h0, s.tm1};
            ecp_pkg::OFF_TM3:  rd_val = {16'h0, s.tm3};
            ecp_pkg::OFF_FLG:  rd_val = {29'h0, s.flg};
            ecp_pkg::OFF_DB:   rd_val = {17'h0, s.dba, 1'b0, s.db};
            ecp_pkg::OFF_CNT:  rd_val = {16'h0, t4_cnt, t2_cnt};
            default:           rd_val = 32'h0;
        endcase
    end

    // next state of the whole unit
    always_comb begin
        logic ovf1;
        logic ovf3;
        logic cmp_hit;
        logic load;
        ovf1    = 1'b0;
        ovf3    = 1'b0;
        cmp_hit = 1'b0;
        load    = 1'b0;
        d       = s;
        d.trig  = 1'b0;
        d.adc   = 1'b0;
        d.q     = s.q + 2'h1;
        d.ack   = req & ~s.ack;
        if (req & ~s.ack)
            d.rdata = rd_val;
        // compare timers count on the instruction cycle
        if (inst_en & s.tctl[ecp_pkg::T1ON]) begin
            d.tm1 = s.tm1 + 16'h0001;
            ovf1  = (s.tm1 == 16'hffff);
        end
        if (inst_en & s.tctl[ecp_pkg::T3ON]) begin
            d.tm3 = s.tm3 + 16'h0001;
            ovf3  = (s.tm3 == 16'hffff);
        end
        // register writes
        if (wr_acc) begin
            case (avs_address)
                ecp_pkg::OFF_UCON: d.ucon = avs_writedata[7:0];
                ecp_pkg::OFF_DLOW: d.dlow = avs_writedata[7:0];
                ecp_pkg::OFF_DSHD: begin
                    if (!pwm_mode)
                        d.shadow = avs_writedata[7:0];
                end
                ecp_pkg::OFF_CMP:  d.cmp  = avs_writedata[15:0];
                ecp_pkg::OFF_PER2: d.per2 = avs_writedata[7:0];
                ecp_pkg::OFF_PER4: d.per4 = avs_writedata[7:0];
                ecp_pkg::OFF_TCTL: d.tctl = avs_writedata[8:0];
                ecp_pkg::OFF_T3C:  d.t3c  = avs_writedata[1:0];
                ecp_pkg::OFF_TM1:  d.tm1  = avs_writedata[15:0];
                ecp_pkg::OFF_TM3:  d.tm3  = avs_writedata[15:0];
                ecp_pkg::OFF_FLG:  d.flg  = s.flg & ~avs_writedata[2:0];
                ecp_pkg::OFF_DB:   d.db   = avs_writedata[6:0];
                default: ;
            endcase
        end
        // compare match and special event trigger
        cmp_hit = inst_en && (s.ucon[3:2] == ecp_pkg::MODE_CMP) &&
                  (csel_cnt == s.cmp);
        if (cmp_hit) begin
            d.flg[ecp_pkg::F_CMP] = 1'b1;
            if (s.ucon[3:0] == ecp_pkg::MODE_CMP_SET && UNIT_ID != 3) begin
                d.trig = 1'b1;
                d.adc  = (UNIT_ID == 2) && s.tctl[ecp_pkg::ADON];
                if (s.t3c[ecp_pkg::CSEL]) begin
                    d.tm3 = 16'h0000;
                    ovf3  = 1'b0;
                end else begin
                    d.tm1 = 16'h0000;
                    ovf1  = 1'b0;
                end
            end
        end
        // overflow flags, set wins over a clearing write
        if (ovf1)
            d.flg[ecp_pkg::F_T1] = 1'b1;
        if (ovf3)
            d.flg[ecp_pkg::F_T3] = 1'b1;
        // pwm sequencing
        case (s.st)
            ecp_pkg::ECP_OFF: begin
                d.pwm = 1'b0;
                if (pwm_mode)
                    d.st = ecp_pkg::ECP_WAIT;
            end
            ecp_pkg::ECP_WAIT: begin
                if (!pwm_mode)
                    d.st = ecp_pkg::ECP_OFF;
                else if (hit_sel)
                    d.st = ecp_pkg::ECP_RUN;
            end
            ecp_pkg::ECP_RUN: begin
                if (!pwm_mode) begin
                    d.st  = ecp_pkg::ECP_OFF;
                    d.pwm = 1'b0;
                end else if (!hit_sel && duty_match) begin
                    d.pwm = 1'b0;
                    d.dba = s.db;
                end
            end
            default: d.st = ecp_pkg::ECP_OFF;
        endcase
        // period boundary: reload buffered controls
        load = pwm_mode && hit_sel && (s.st != ecp_pkg::ECP_OFF);
        if (load) begin
            d.shadow = s.dlow;
            d.latch  = s.ucon[5:4];
            d.cfg    = s.ucon[7:6];
            d.pol    = s.ucon[1:0];
            d.dba    = s.db;
            d.pwm    = ({s.dlow, s.ucon[5:4]} != 10'h000);
        end
        // output steering and polarity
        d.outs = 4'h0;
        if (d.st == ecp_pkg::ECP_RUN) begin
            d.outs[0] = d.pwm ^ d.pol[1];
            if (d.cfg != 2'h0)
                d.outs[1] = d.pwm ^ d.pol[0];
            if (d.cfg[0]) begin
                d.outs[2] = d.pwm ^ d.pol[1];
                d.outs[3] = d.pwm ^ d.pol[0];
            end
        end
        if (UNIT_ID == 3 && d.st == ecp_pkg::ECP_RUN && d.cfg[0])
            d.shared = d.outs[3];
        else
            d.shared = unit_four_level;
    end

    // state register
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s      <= '0;
            s.per2 <= ecp_pkg::RST_PER;
            s.per4 <= ecp_pkg::RST_PER;
        end else begin
            s <= d;
        end
    end

    // pin outputs from flip-flops
    assign pwm_out_a      = s.outs[0];
    assign pwm_out_b      = s.outs[1];
    assign pwm_out_c      = s.outs[2];
    assign pwm_out_d      = s.outs[3];
    assign shared_pin_out = s.shared;
    assign sp_trigger     = s.trig;
    assign adc_start      = s.adc;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_trig;
        inst_en && s.ucon[3:0] == ecp_pkg::MODE_CMP_SET && UNIT_ID != 3 &&
        csel_cnt == s.cmp |=> s.trig;
    endproperty
    a_trig: assert property (p_trig)
        else $error("special event trigger missing on compare match");

    property p_reset;
        s.trig |-> (s.t3c[ecp_pkg::CSEL] ? s.tm3 : s.tm1) == 16'h0000;
    endproperty
    a_reset: assert property (p_reset)
        else $error("selected timer not reset by trigger");

    property p_adc;
        s.trig |-> s.adc == (UNIT_ID == 2 && $past(s.tctl[ecp_pkg::ADON]));
    endproperty
    a_adc: assert property (p_adc)
        else $error("conversion start does not follow trigger");

    property p_unit3;
        UNIT_ID == 3 && inst_en && s.ucon[3:0] == ecp_pkg::MODE_CMP_SET &&
        csel_cnt == s.cmp |=> !s.trig && s.flg[ecp_pkg::F_CMP];
    endproperty
    a_unit3: assert property (p_unit3)
        else $error("unit three did not act as software compare");

    property p_noflag;
        s.trig && !$past(wr_acc) |->
            (s.t3c[ecp_pkg::CSEL] ? !$rose(s.flg[ecp_pkg::F_T3])
                                  : !$rose(s.flg[ecp_pkg::F_T1]));
    endproperty
    a_noflag: assert property (p_noflag)
        else $error("trigger reset set a timer flag");

    property p_buffered;
        !$stable(s.pol) || !$stable(s.cfg) |-> $past(hit_sel);
    endproperty
    a_buffered: assert property (p_buffered)
        else $error("pwm control changed off the period boundary");

    property p_wait;
        s.st == ecp_pkg::ECP_WAIT |-> s.outs == 4'h0;
    endproperty
    a_wait: assert property (p_wait)
        else $error("pwm output before first timer restart");

    property p_set;
        $rose(s.pwm) |-> $past(hit_sel) &&
            $past({s.dlow, s.ucon[5:4]}) != 10'h000;
    endproperty
    a_set: assert property (p_set)
        else $error("pwm set without a period match or with zero duty");

    property p_copy;
        hit_sel && pwm_mode && s.st != ecp_pkg::ECP_OFF |=>
            s.shadow == $past(s.dlow) && s.latch == $past(s.ucon[5:4]);
    endproperty
    a_copy: assert property (p_copy)
        else $error("duty not copied at period match");

    property p_clear;
        $fell(s.pwm) |-> $past(duty_match) || $past(hit_sel) ||
            $past(s.ucon[3:2]) != ecp_pkg::MODE_PWM;
    endproperty
    a_clear: assert property (p_clear)
        else $error("pwm cleared without a duty match");

    c_trig: cover property (s.trig);
    c_adc: cover property (s.adc);
    c_pwm: cover property ($rose(s.pwm) ##[1:600] $fell(s.pwm));
    c_quad: cover property (s.st == ecp_pkg::ECP_RUN && s.cfg[0]);
endmodule
`default_nettype wire

// File: include/ecp_pkg.sv
// constants, field positions and state type of the enhanced compare/pwm unit
// assumes a single mclk domain; one oscillator period equals one mclk period
package ecp_pkg;
    // register byte addresses
    localparam logic [7:0] OFF_UCON = 8'h00;
    localparam logic [7:0] OFF_DLOW = 8'h04;
    localparam logic [7:0] OFF_DSHD = 8'h08;
    localparam logic [7:0] OFF_CMP  = 8'h0c;
    localparam logic [7:0] OFF_PER2 = 8'h10;
    localparam logic [7:0] OFF_PER4 = 8'h14;
    localparam logic [7:0] OFF_TCTL = 8'h18;
    localparam logic [7:0] OFF_T3C  = 8'h1c;
    localparam logic [7:0] OFF_TM1  = 8'h20;
    localparam logic [7:0] OFF_TM3  = 8'h24;
    localparam logic [7:0] OFF_FLG  = 8'h28;
    localparam logic [7:0] OFF_DB   = 8'h2c;
    localparam logic [7:0] OFF_CNT  = 8'h30;
    // timer control fields
    localparam int T2ON = 0;
    localparam int T2PS = 1;
    localparam int T4ON = 3;
    localparam int T4PS = 4;
    localparam int T1ON = 6;
    localparam int T3ON = 7;
    localparam int ADON = 8;
    // timer three control fields
    localparam int CSEL = 0;
    localparam int PSEL = 1;
    // flag bits
    localparam int F_T1  = 0;
    localparam int F_T3  = 1;
    localparam int F_CMP = 2;
    // mode codes
    localparam logic [3:0] MODE_CMP_SWI = 4'ha;
    localparam logic [3:0] MODE_CMP_SET = 4'hb;
    localparam logic [1:0] MODE_CMP     = 2'h2;
    localparam logic [1:0] MODE_PWM     = 2'h3;
    localparam logic [1:0] PS_1         = 2'h0;
    localparam logic [1:0] PS_4         = 2'h1;
    // reset values
    localparam logic [7:0] RST_PER = 8'hff;
    // one instruction cycle is four oscillator periods
    localparam int TOSC_PER_INST = 4;
    localparam logic [1:0] Q_LAST = 2'(TOSC_PER_INST - 1);
    typedef enum logic [1:0] {ECP_OFF, ECP_WAIT, ECP_RUN} ecp_state_t;
endpackage

// File: verilog/ecp_period_timer.sv
// eight-bit period timer with 1/4/16 prescaler, pwm time base
// assumes inst_en pulses once per instruction cycle on mclk
`timescale 1ns/1ps
`default_nettype none
module ecp_period_timer (
    input  wire logic       mclk,     // system clock
    input  wire logic       sys_rst,  // async reset, high
    input  wire logic       inst_en,  // instruction cycle pulse
    input  wire logic       run,      // timer on
    input  wire logic [1:0] presc,    // prescale select
    input  wire logic [7:0] period,   // period limit
    input  wire logic [1:0] q_phase,  // quarter-cycle phase
    output logic      [7:0] count,    // count after this edge
    output logic      [1:0] sub,      // sub-count after this edge
    output logic            hit       // period restart pulse
);
    typedef struct packed {
        logic [3:0] pre;
        logic [7:0] cnt;
    } ecp_tmr_st_t;
    ecp_tmr_st_t s;
    ecp_tmr_st_t d;
    logic        wrap;

    // prescaler wrap, no postscaler in this path
    always_comb begin
        if (presc == ecp_pkg::PS_1)
            wrap = 1'b1;
        else if (presc == ecp_pkg::PS_4)
            wrap = (s.pre[1:0] == 2'h3);
        else
            wrap = (s.pre == 4'hf);
    end

    // position as it stands after this edge, so a duty match clears the
    // registered output on entry to its position, not one cycle late
    always_comb begin
        if (presc == ecp_pkg::PS_1)
            sub = q_phase + 2'h1;
        else if (presc == ecp_pkg::PS_4)
            sub = d.pre[1:0];
        else
            sub = d.pre[3:2];
    end

    assign hit   = inst_en & run & wrap & (s.cnt == period);
    assign count = d.cnt;

    // count and clear on the increment after the limit
    always_comb begin
        d = s;
        if (inst_en & run) begin
            d.pre = s.pre + 4'h1;
            if (wrap)
                d.cnt = (s.cnt == period) ? 8'h00 : s.cnt + 8'h01;
        end
    end

    // state register
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            s <= '0;
        else
            s <= d;
    end

    property p_clear;
        @(posedge mclk) disable iff (sys_rst)
        hit |=> (s.cnt == 8'h00) &&
            ($past(presc) == ecp_pkg::PS_1 || s.pre[1:0] == 2'h0);
    endproperty
    a_clear: assert property (p_clear)
        else $error("timer not cleared after period match");
endmodule
`default_nettype wire

// File: tb/ecp_switch_model.sv
// switch driver model: counts the cycles its gate input is driven high
// assumes one mclk domain and a gate pin already set up as an output
`timescale 1ns/1ps
`default_nettype none
module ecp_switch_model (
    input  wire logic mclk,   // system clock
    input  wire logic clr,    // restart the count
    input  wire logic gate,   // pwm pin into the driver
    output var  int   hi_cnt  // cycles seen high
);
    // the pin is only ever taken as a driven output, never read back
    always @(posedge mclk) begin
        if (clr) begin
            hi_cnt <= 0;
        end else if (gate === 1'b1) begin
            hi_cnt <= hi_cnt + 1;
        end
    end
endmodule
`default_nettype wire

// File: tb/tb.sv
// bench for two enhanced compare/pwm units (units two and three)
// assumes the unit package is compiled first; bus is avalon-mm
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        mclk, sys_rst, u4lvl, u4_prev, clr;
    logic [7:0]  addr;
    logic [31:0] wdata, q;
    logic        rd [2];
    logic        wr [2];
    logic [31:0] rdat [2];
    logic        wq [2];
    logic        pa, pb, pc, pd, sh, trig, adc, trig3, adc3;
    int          hi, t, err_count, check_count;

    ecp_unit #(.UNIT_ID(2)) DUT (
        .mclk(mclk), .sys_rst(sys_rst), .avs_address(addr),
        .avs_read(rd[0]), .avs_write(wr[0]), .avs_writedata(wdata),
        .avs_readdata(rdat[0]), .avs_waitrequest(wq[0]),
        .unit_four_level(1'b0), .pwm_out_a(), .pwm_out_b(),
        .pwm_out_c(), .pwm_out_d(), .shared_pin_out(),
        .sp_trigger(trig), .adc_start(adc));
    ecp_unit #(.UNIT_ID(3)) DUT3 (
        .mclk(mclk), .sys_rst(sys_rst), .avs_address(addr),
        .avs_read(rd[1]), .avs_write(wr[1]), .avs_writedata(wdata),
        .avs_readdata(rdat[1]), .avs_waitrequest(wq[1]),
        .unit_four_level(u4lvl), .pwm_out_a(pa), .pwm_out_b(pb),
        .pwm_out_c(pc), .pwm_out_d(pd), .shared_pin_out(sh),
        .sp_trigger(trig3), .adc_start(adc3));
    ecp_switch_model SW (.mclk(mclk), .clr(clr), .gate(pa), .hi_cnt(hi));

    // clock and a busy unit four pin
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        u4lvl   <= ~u4lvl;
        u4_prev <= u4lvl;
    end

    task give_verdict;
        $display("errors=%0d checks=%0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task bus(input int u, input logic w, input logic [7:0] a,
             input logic [31:0] d);
        int n;
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        rd[u] <= !w;
        wr[u] <= w;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (wq[u] !== 1'b0 && n < 50);
        q = rdat[u];
        rd[u] <= 1'b0;
        wr[u] <= 1'b0;
        if (n >= 50) begin
            err_count++;
            give_verdict;
        end
    endtask

    task rdchk(input int u, input logic [7:0] a, input logic [31:0] e);
        bus(u, 1'b0, a, 32'h0);
        chk(q, e);
    endtask

    // settle s cycles, then count high cycles of output a over n
    task duty(input int s, input int n);
        repeat (s) @(posedge mclk);
        @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask

    task wait_trig;
        t = 0;
        do begin
            @(negedge mclk);
            t++;
        end while (trig !== 1'b1 && t < 200);
        if (t >= 200) begin
            err_count++;
            give_verdict;
        end
    endtask

    task pins(input logic four);
        repeat (8) begin
            @(negedge mclk);
            chk({pb, pc, pd, sh}, four ? {4{pa}} : {3'h0, u4_prev});
        end
    endtask

    // watchdog
    initial begin
        repeat (30000) @(posedge mclk);
        err_count++;
        give_verdict;
    end

    // main sequence
    initial begin
        mclk = 0; sys_rst = 1; u4lvl = 0; u4_prev = 0; clr = 0;
        addr = 8'h00; wdata = 32'h0; rd = '{2{1'b0}}; wr = '{2{1'b0}};
        err_count = 0; check_count = 0;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        rdchk(1, ecp_pkg::OFF_PER2, 32'hff);
        rdchk(1, ecp_pkg::OFF_UCON, 32'h0);
        rdchk(1, 8'h40, 32'h0);
        // special event trigger on unit two
        bus(0, 1, ecp_pkg::OFF_CMP, 32'h5);
        bus(0, 1, ecp_pkg::OFF_UCON, 32'h0b);
        bus(0, 1, ecp_pkg::OFF_TCTL, 32'h140);
        wait_trig;
        wait_trig;
        chk(t, 24);
        chk(adc, 1);
        bus(0, 1, ecp_pkg::OFF_TCTL, 32'h40);
        wait_trig;
        wait_trig;
        chk(adc, 0);
        rdchk(0, ecp_pkg::OFF_FLG, 32'h4);
        bus(0, 0, ecp_pkg::OFF_TM1, 32'h0);
        chk(q <= 32'h5, 1);
        // trigger on the count that would overflow timer one
        bus(0, 1, ecp_pkg::OFF_CMP, 32'hffff);
        bus(0, 1, ecp_pkg::OFF_TM1, 32'hfff0);
        wait_trig;
        rdchk(0, ecp_pkg::OFF_FLG, 32'h4);
        // unit three has no trigger: mode 1011 acts as 1010
        bus(1, 1, ecp_pkg::OFF_CMP, 32'h5);
        bus(1, 1, ecp_pkg::OFF_UCON, 32'h0b);
        bus(1, 1, ecp_pkg::OFF_TCTL, 32'h40);
        t = 0;
        repeat (60) begin
            @(negedge mclk);
            if (trig3 !== 1'b0 || adc3 !== 1'b0) t++;
        end
        chk(t, 0);
        bus(1, 0, ecp_pkg::OFF_TM1, 32'h0);
        chk(q > 32'h5, 1);
        rdchk(1, ecp_pkg::OFF_FLG, 32'h4);
        // pwm on unit three, timer two, limit 1, prescale 1
        bus(1, 1, ecp_pkg::OFF_TCTL, 32'h0);
        bus(1, 1, ecp_pkg::OFF_PER2, 32'h1);
        bus(1, 1, ecp_pkg::OFF_DLOW, 32'h0);
        bus(1, 1, ecp_pkg::OFF_UCON, 32'h6c);
        duty(0, 16);
        chk(hi, 0);
        bus(1, 1, ecp_pkg::OFF_TCTL, 32'h1);
        duty(16, 16);
        chk(hi, 4);
        pins(1);
        bus(1, 1, ecp_pkg::OFF_DLOW, 32'h1);
        bus(1, 1, ecp_pkg::OFF_UCON, 32'h4c);
        duty(16, 16);
        chk(hi, 8);
        rdchk(1, ecp_pkg::OFF_DSHD, 32'h1);
        bus(1, 1, ecp_pkg::OFF_DSHD, 32'h33);
        rdchk(1, ecp_pkg::OFF_DSHD, 32'h1);
        bus(1, 1, ecp_pkg::OFF_UCON, 32'h6f);
        duty(16, 16);
        chk(hi, 4);
        bus(1, 1, ecp_pkg::OFF_DLOW, 32'h0);
        bus(1, 1, ecp_pkg::OFF_UCON, 32'h4c);
        duty(16, 16);
        chk(hi, 0);
        bus(1, 1, ecp_pkg::OFF_DLOW, 32'hff);
        duty(16, 16);
        chk(hi, 16);
        // prescale 4, then timer four as the time base
        bus(1, 1, ecp_pkg::OFF_DLOW, 32'h1);
        bus(1, 1, ecp_pkg::OFF_TCTL, 32'h3);
        duty(64, 64);
        chk(hi, 32);
        bus(1, 1, ecp_pkg::OFF_PER4, 32'h1);
        bus(1, 1, ecp_pkg::OFF_TCTL, 32'h8);
        bus(1, 1, ecp_pkg::OFF_T3C, 32'h2);
        duty(64, 16);
        chk(hi, 8);
        // single output: unit four keeps its pin
        bus(1, 1, ecp_pkg::OFF_UCON, 32'h0c);
        repeat (16) @(posedge mclk);
        pins(0);
        give_verdict;
    end
endmodule
`default_nettype wire
